// file: core/ldsd_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the led decode and scan driver
// Assumes: 100 MHz ref_clk, byte-addressed avalon slave, 32-bit data
// Notes:   segment vectors are {dp,a,b,c,d,e,f,g}, glyphs {a..g}
//////////////////////////////////////////////////////////////////////////////
package ldsd_pkg;
    // bus layout
    localparam int          ADDR_W        = 6;
    localparam int          DATA_W        = 32;
    localparam logic [5:0]  REG_CTRL      = 6'h00;
    localparam logic [5:0]  REG_STATUS    = 6'h04;
    localparam logic [5:0]  REG_DIGIT0    = 6'h20;
    // control word fields
    localparam int          CTRL_BANK_BIT = 3;
    localparam int          CTRL_RUN_BIT  = 4;
    localparam int          CTRL_DEC_BIT  = 5;
    localparam int          CTRL_HEX_BIT  = 6;
    localparam logic [7:0]  CTRL_RESET    = 8'h30;
    // digit word fields and reset contents (blank in code b)
    localparam int          POINT_BIT     = 7;
    localparam logic [7:0]  WORD_RESET    = 8'hff;
    localparam logic [3:0]  NIB_RESET     = 4'hf;
    // status fields
    localparam int          ST_RUN_BIT    = 0;
    localparam int          ST_GAP_BIT    = 1;
    localparam int          ST_DIG_LSB    = 4;
    localparam int          ST_FMT_LSB    = 8;
    // timing
    localparam int          CLK_NS        = 10;
    localparam int          US_NS         = 1000;
    localparam int          TICK_CYC      = US_NS / CLK_NS;
    localparam int          SLOT_ON_US    = 320;
    localparam int          GAP_US        = 10;
    localparam int          GAP_MIN_US    = 2;
    // scan order: slot n uses digit index bits [3n+2:3n]
    localparam logic [23:0] SCAN_ORDER    = 24'h4efc21;
    // three-level pin codes after external comparators
    localparam logic [1:0]  TRI_HIGH      = 2'h3;
    localparam logic [1:0]  TRI_LOW       = 2'h0;
    // glyph tables
    localparam logic [6:0]  HEX_TABLE [16] = '{
        7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
        7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3d, 7'h4f, 7'h47};
    localparam logic [6:0]  CODEB_TABLE [16] = '{
        7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
        7'h7f, 7'h7b, 7'h01, 7'h4f, 7'h37, 7'h0e, 7'h67, 7'h00};

    typedef enum logic [1:0] {FMT_HEX, FMT_CODEB, FMT_RAW} ldsd_fmt_type;
    typedef enum logic [1:0] {SC_IDLE, SC_GAP, SC_ON} ldsd_scan_type;
endpackage

// file: core/ldsd_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: decode eight display words and multiplex them onto led drives
// Assumes: avalon-mm slave with one wait cycle per access
// Notes:   all drive outputs are registered; polarity set by COMMON_ANODE
//
// How it works
// - control bits 6..5 pick the display format
// - decoded: bits 3..0 code, bit 7 point
// - hex shows 0-9 then A b C d E F
// - code b shows 0-9, dash E H L P blank
// - raw format maps each bit to one segment
// - raw: one lights segment, zero lights point
// - three-level pin: hex, code b, shutdown
// - shutdown stops scan, all drivers off
// - shutdown still accepts and keeps data
// - control bit 4 low enters shutdown
// - all FF in code b is blank
// - all 80 in raw format is blank
// - each digit on about 320 us
// - gap between digits 10 us, minimum 2
// - gap keeps digits and segments off
// - scan order 2 5 1 7 8 6 4 3
// - each digit gets one eighth duty
// - bit 3 selects bank when decoded
// - decimal point shared by both banks
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module ldsd_top
    import ldsd_pkg::*;
#(
    parameter bit SEQ_ENTRY    = 1'b1,       // 0: random-access variant
    parameter bit COMMON_ANODE = 1'b1,
    parameter int TICK_CYC_P   = TICK_CYC,   // cycles per microsecond
    parameter int SLOT_ON_P    = SLOT_ON_US, // digit on time in us
    parameter int GAP_P        = GAP_US      // blanking gap in us
) (
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [DATA_W-1:0]   avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [DATA_W-1:0]   avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic [1:0]          tri_level_format_select,
    output logic      [7:0]          digit_drv,
    output logic      [7:0]          seg_drv
);

    localparam int         ON_CYC      = SLOT_ON_P * TICK_CYC_P;
    localparam int         GAP_MIN_CYC = GAP_MIN_US * TICK_CYC_P;
    localparam logic [7:0] DIG_INV     = COMMON_ANODE ? 8'h00 : 8'hff;
    localparam logic [7:0] SEG_INV     = COMMON_ANODE ? 8'hff : 8'h00;

    logic [7:0]    ctrl_r;
    logic [7:0]    raw_a_r [8];   // bank a nibble, raw bits and point
    logic [3:0]    raw_b_r [8];   // bank b nibble
    logic [1:0]    tri_s1_r;
    logic [1:0]    tri_s2_r;
    logic          waitreq_r;
    logic [31:0]   rdata_r;
    logic [31:0]   tick_cnt_r;
    logic [31:0]   us_cnt_r;
    logic [2:0]    pos_r;
    ldsd_scan_type scan_r;
    logic [7:0]    digit_r;
    logic [7:0]    seg_r;
    logic          run;
    ldsd_fmt_type  fmt;
    logic          bank_sel;
    logic          tick;
    logic          take;
    logic          wr_ok;
    logic          is_digit;
    logic [2:0]    wr_idx;
    logic [2:0]    cur_dig;
    logic [7:0]    cur_word;
    logic [3:0]    cur_nib;
    logic [7:0]    seg_on;
    logic [31:0]   rd_val;

    //////////////////////////////////////////////////////////////////////////
    // three-level pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            tri_s1_r <= 2'h0;
            tri_s2_r <= 2'h0;
        end else begin
            tri_s1_r <= tri_level_format_select;
            tri_s2_r <= tri_s1_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // effective format, shutdown and bank
    always_comb begin
        if (SEQ_ENTRY) begin
            run = ctrl_r[CTRL_RUN_BIT];
            if (!ctrl_r[CTRL_DEC_BIT]) begin
                fmt = FMT_RAW;
            end else if (ctrl_r[CTRL_HEX_BIT]) begin
                fmt = FMT_HEX;
            end else begin
                fmt = FMT_CODEB;
            end
        end else begin
            run = (tri_s2_r != TRI_LOW);
            fmt = (tri_s2_r == TRI_HIGH) ? FMT_HEX : FMT_CODEB;
        end
        bank_sel = SEQ_ENTRY && (fmt != FMT_RAW) && ctrl_r[CTRL_BANK_BIT];
    end

    //////////////////////////////////////////////////////////////////////////
    // bus decode: a request completes in the cycle waitrequest is low
    assign take     = (avs_read || avs_write) && !waitreq_r;
    assign wr_ok    = take && avs_write && avs_byteenable[0];
    assign is_digit = avs_address[5] && (avs_address[1:0] == 2'h0);
    assign wr_idx   = avs_address[4:2];

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            waitreq_r <= 1'b1;
        end else begin
            waitreq_r <= !((avs_read || avs_write) && waitreq_r);
        end
    end

    // control register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_ok && SEQ_ENTRY && avs_address == REG_CTRL) begin
            ctrl_r <= avs_writedata[7:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // display memory, written in any scan state
    // writes kept in shutdown
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                raw_a_r[i] <= WORD_RESET;
                raw_b_r[i] <= NIB_RESET;
            end
        end else if (wr_ok && is_digit) begin
            if (fmt == FMT_RAW) begin
                raw_a_r[wr_idx] <= avs_writedata[7:0];
            end else begin
                raw_a_r[wr_idx][POINT_BIT] <= avs_writedata[POINT_BIT];
                if (bank_sel) begin
                    raw_b_r[wr_idx] <= avs_writedata[3:0];
                end else begin
                    raw_a_r[wr_idx][3:0] <= avs_writedata[3:0];
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read data, loaded while the request waits
    always_comb begin
        rd_val = 32'h0;
        if (avs_address == REG_CTRL) begin
            rd_val[7:0] = ctrl_r;
        end else if (avs_address == REG_STATUS) begin
            rd_val[ST_RUN_BIT]         = (scan_r != SC_IDLE);
            rd_val[ST_GAP_BIT]         = (scan_r == SC_GAP);
            rd_val[ST_DIG_LSB +: 3]    = cur_dig;
            rd_val[ST_FMT_LSB +: 2]    = fmt;
        end else if (is_digit) begin
            if (fmt == FMT_RAW) begin
                rd_val[7:0] = raw_a_r[wr_idx];
            end else begin
                rd_val[POINT_BIT] = raw_a_r[wr_idx][POINT_BIT];
                rd_val[3:0] = bank_sel ? raw_b_r[wr_idx]
                                       : raw_a_r[wr_idx][3:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata_r <= 32'h0;
        end else if (avs_read && waitreq_r) begin
            rdata_r <= rd_val;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // microsecond tick; the divider stops in shutdown
    // oscillator halted
    assign tick = (tick_cnt_r == TICK_CYC_P - 1);

    always_ff @(posedge ref_clk) begin
        if (!rstn || !run || tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // scan sequencer: gap, then on time, then next slot
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            scan_r   <= SC_IDLE;
            us_cnt_r <= 32'h0;
            pos_r    <= 3'h0;
        end else if (!run) begin
            scan_r   <= SC_IDLE;
            us_cnt_r <= 32'h0;
        end else begin
            unique case (scan_r)
                SC_IDLE: begin
                    scan_r   <= SC_GAP;
                    us_cnt_r <= 32'h0;
                end
                SC_GAP: begin
                    if (tick) begin
                        if (us_cnt_r == GAP_P - 1) begin
                            scan_r   <= SC_ON;
                            us_cnt_r <= 32'h0;
                        end else begin
                            us_cnt_r <= us_cnt_r + 32'h1;
                        end
                    end
                end
                SC_ON: begin
                    if (tick) begin
                        if (us_cnt_r == SLOT_ON_P - 1) begin
                            scan_r   <= SC_GAP;
                            us_cnt_r <= 32'h0;
                            pos_r    <= pos_r + 3'h1;
                        end else begin
                            us_cnt_r <= us_cnt_r + 32'h1;
                        end
                    end
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // slot decode
    // fixed scan order table
    assign cur_dig  = SCAN_ORDER[pos_r * 3 +: 3];
    assign cur_word = raw_a_r[cur_dig];
    assign cur_nib  = bank_sel ? raw_b_r[cur_dig] : cur_word[3:0];

    always_comb begin
        unique case (fmt)
            FMT_RAW:  seg_on = {~cur_word[7], cur_word[6], cur_word[5],
                                cur_word[4], cur_word[0], cur_word[3],
                                cur_word[1], cur_word[2]};
            FMT_HEX:  seg_on = {~cur_word[POINT_BIT], HEX_TABLE[cur_nib]};
            default:  seg_on = {~cur_word[POINT_BIT], CODEB_TABLE[cur_nib]};
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // registered drives; off outside the on time
    // gap forces all off
    always_ff @(posedge ref_clk) begin
        if (!rstn || scan_r != SC_ON) begin
            digit_r <= DIG_INV;
            seg_r   <= SEG_INV;
        end else begin
            digit_r <= (8'h01 << cur_dig) ^ DIG_INV;
            seg_r   <= seg_on ^ SEG_INV;
        end
    end

    assign digit_drv       = digit_r;
    assign seg_drv         = seg_r;
    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = waitreq_r;

    //////////////////////////////////////////////////////////////////////////
    // checks
    logic [31:0] on_len_r;
    logic [31:0] gap_len_r;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            on_len_r  <= 32'h0;
            gap_len_r <= 32'h0;
        end else begin
            on_len_r  <= (scan_r == SC_ON) ? on_len_r + 32'h1 : 32'h0;
            gap_len_r <= (scan_r == SC_GAP) ? gap_len_r + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_shutdown_dark: assert property (
        !run |=> ##1 (digit_drv == DIG_INV && seg_drv == SEG_INV))
        else $error("drivers active during shutdown");
    a_gap_dark: assert property (
        scan_r == SC_GAP |=> (digit_drv == DIG_INV && seg_drv == SEG_INV))
        else $error("drivers active in blanking gap");
    a_one_digit: assert property (
        scan_r == SC_ON |=> $onehot(digit_drv ^ DIG_INV))
        else $error("not exactly one digit driven");
    a_slot_length: assert property (
        scan_r == SC_GAP && $past(scan_r) == SC_ON && run
        |-> $past(on_len_r) == ON_CYC - 1)
        else $error("digit on time wrong");
    a_gap_minimum: assert property (
        scan_r == SC_ON && $past(scan_r) == SC_GAP
        |-> $past(gap_len_r) >= GAP_MIN_CYC - 1)
        else $error("blanking gap too short");
    a_scan_step: assert property (
        $changed(pos_r) |-> pos_r == $past(pos_r) + 3'h1)
        else $error("scan slot skipped");
    a_ctrl_shutdown: assert property (
        SEQ_ENTRY && wr_ok && avs_address == REG_CTRL
        && !avs_writedata[CTRL_RUN_BIT] |=> ##1 scan_r == SC_IDLE)
        else $error("shutdown bit ignored");
    a_codeb_blank: assert property (
        scan_r == SC_ON && fmt == FMT_CODEB && cur_word == 8'hff
        && !bank_sel |=> seg_drv == SEG_INV)
        else $error("code b FF not blank");
    a_raw_blank: assert property (
        scan_r == SC_ON && fmt == FMT_RAW && cur_word == 8'h80
        |=> seg_drv == SEG_INV)
        else $error("raw 80 not blank");
    a_bus_answer: assert property (
        (avs_read || avs_write) && waitreq_r |=> !avs_waitrequest)
        else $error("waitrequest not released");

    c_full_scan:  cover property (scan_r == SC_ON && pos_r == 3'h7);
    c_shutdown:   cover property (run ##1 !run);
    c_raw_shown:  cover property (scan_r == SC_ON && fmt == FMT_RAW);
    c_bank_b:     cover property (scan_r == SC_ON && bank_sel);

endmodule // ldsd_top

// file: testbench/ldsd_bus_model.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: avalon-mm master standing in for the host processor
// Assumes: one request at a time, slave answers through waitrequest
// Notes:   signals move by nba just after a rising edge, except the blocking idle values at time zero
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module ldsd_bus_model
    import ldsd_pkg::*;
(
    input  wire logic              ref_clk,
    output logic [ADDR_W-1:0]      avs_address,
    output logic                   avs_read,
    output logic                   avs_write,
    output logic [DATA_W-1:0]      avs_writedata,
    output logic [3:0]             avs_byteenable,
    input  wire logic [DATA_W-1:0] avs_readdata,
    input  wire logic              avs_waitrequest
);
    // idle bus at time zero
    initial begin
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = '0;
        avs_byteenable = 4'h0;
    end

    // one transfer; the wait has no bound of its own, the bench timeout cuts it
    task automatic xfer(input logic is_rd, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [3:0] be,
                        output logic [DATA_W-1:0] q);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= is_rd;
        avs_write      <= !is_rd;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk); // keeps the next request off this time step
    endtask
endmodule // ldsd_bus_model

// file: testbench/led_decode_scan_driver_tb.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench, sequential and random-access variants
// Assumes: shortened timing, gap 8 and on time 8 cycles
// Notes:   a monitor follows every digit slot of both instances
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module led_decode_scan_driver_tb
    import ldsd_pkg::*;
;
    localparam int         TK    = 2;
    localparam int         SON   = 4;
    localparam int         GP    = 4;
    localparam int         ON_C  = SON * TK;
    localparam int         GAP_C = GP * TK;
    localparam logic [6:0] HX [16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33,
        7'h5b, 7'h5f, 7'h70, 7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3d,
        7'h4f, 7'h47};
    localparam logic [6:0] CB [16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33,
        7'h5b, 7'h5f, 7'h70, 7'h7f, 7'h7b, 7'h01, 7'h4f, 7'h37, 7'h0e,
        7'h67, 7'h00};
    localparam int         ORD [8] = '{1, 4, 0, 6, 7, 5, 3, 2};
    logic                  ref_clk;
    logic                  rstn;
    logic [ADDR_W-1:0]     adr;
    logic                  rd_s;
    logic                  wr_s;
    logic [DATA_W-1:0]     wdat;
    logic [DATA_W-1:0]     rdat;
    logic [3:0]            be;
    logic                  wtr;
    logic [1:0]            tri_sel;
    logic [7:0]            dg0;
    logic [7:0]            sg0;
    logic [7:0]            dg1;
    logic [7:0]            sg1;
    logic [7:0]            ad [2];
    logic [7:0]            as_ [2];
    logic [7:0]            wa [8];
    logic [3:0]            nb [8];
    ldsd_fmt_type          efmt [2];
    logic                  ebank;
    logic                  en1;
    logic                  chk_en [2];
    logic                  tim_en [2];
    logic                  sd_e [2];
    logic                  on_f [2];
    logic                  skip [2];
    int                    cnt [2];
    int                    pos [2];
    int                    errors;
    int                    checks_done;
    int                    cyc;
    logic [15:0]           lf;
    logic [31:0]           q;

    ldsd_bus_model bus (.ref_clk(ref_clk), .avs_address(adr),
        .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdat),
        .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wtr));
    ldsd_top #(.TICK_CYC_P(TK), .SLOT_ON_P(SON), .GAP_P(GP)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .avs_address(adr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be),
        .avs_readdata(rdat), .avs_waitrequest(wtr),
        .tri_level_format_select(tri_sel), .digit_drv(dg0), .seg_drv(sg0));
    ldsd_top #(.SEQ_ENTRY(1'b0), .COMMON_ANODE(1'b0), .TICK_CYC_P(TK),
        .SLOT_ON_P(SON), .GAP_P(GP)) uut_ra (
        .ref_clk(ref_clk), .rstn(rstn), .avs_address(adr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be),
        .avs_readdata(), .avs_waitrequest(),
        .tri_level_format_select(tri_sel), .digit_drv(dg1), .seg_drv(sg1));

    // active-high views: anode instance, then cathode instance
    assign ad[0]  = dg0;
    assign as_[0] = ~sg0;
    assign ad[1]  = ~dg1;
    assign as_[1] = sg1;

    //////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // expected lit segments {dp,a,b,c,d,e,f,g} of one digit
    function automatic logic [7:0] exp_seg(int i, int n);
        logic [3:0] c;
        c = (i == 0 && ebank) ? nb[n] : wa[n][3:0];
        if (efmt[i] == FMT_RAW)
            return {~wa[n][7], wa[n][6:4], wa[n][0], wa[n][3], wa[n][1],
                    wa[n][2]};
        if (efmt[i] == FMT_HEX)
            return {~wa[n][7], HX[c]};
        return {~wa[n][7], CB[c]};
    endfunction

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////
    // run limit; a hang counts as a mismatch
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end

    // slot monitor: order, gap and on lengths, blanking, decoded segments
    always @(posedge ref_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (!rstn || !tim_en[i]) skip[i] = 1'b1;
            if (!rstn) begin
                pos[i]  = 0;
                on_f[i] = 1'b0;
                cnt[i]  = 0;
            end else if (ad[i] != 8'h00) begin
                if (!on_f[i]) begin
                    chk(ad[i], 8'h01 << ORD[pos[i]]);
                    chk(sd_e[i], 1'b0);
                    if (!skip[i]) chk(cnt[i], GAP_C);
                    skip[i] = !tim_en[i];
                    pos[i]  = (pos[i] + 1) % 8;
                    cnt[i]  = 0;
                end
                if (chk_en[i])
                    chk(as_[i], exp_seg(i, ORD[(pos[i] + 7) % 8]));
                on_f[i] = 1'b1;
                cnt[i]++;
            end else begin
                if (on_f[i] && !skip[i]) chk(cnt[i], ON_C);
                chk(as_[i], 8'h00);
                if (on_f[i]) cnt[i] = 0;
                on_f[i] = 1'b0;
                cnt[i]++;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    task automatic ctl(input logic [7:0] v);
        bus.xfer(1'b0, REG_CTRL, {24'h0, v}, 4'hf, q);
        ebank   = v[3] & v[5];
        efmt[0] = !v[5] ? FMT_RAW : (v[6] ? FMT_HEX : FMT_CODEB);
    endtask

    task automatic wd(input int n, input logic [7:0] d);
        bus.xfer(1'b0, REG_DIGIT0 + 6'(4 * n), {24'h0, d}, 4'hf, q);
        if (efmt[0] == FMT_RAW)
            wa[n] = d;
        else if (ebank) begin
            nb[n]    = d[3:0];
            wa[n][7] = d[7];
        end else
            wa[n] = {d[7], wa[n][6:4], d[3:0]};
    endtask

    // watch two full scans with segment checking on
    task automatic look(input string nm);
        repeat (3) @(posedge ref_clk);
        chk_en[0] <= 1'b1;
        chk_en[1] <= en1;
        repeat (300) @(posedge ref_clk);
        chk_en[0] <= 1'b0;
        chk_en[1] <= 1'b0;
        $display("test %s done", nm);
    endtask

    // kind 0: counting codes from base, 1: random bytes, 2: all equal base
    task automatic pass(input int base, input int kind, input string nm);
        for (int n = 0; n < 8; n++) begin
            lf = lfsr(lf);
            if (kind == 0)
                wd(n, {lf[7], 3'h0, 4'(base + n)});
            else
                wd(n, kind == 1 ? lf[7:0] : 8'(base));
        end
        look(nm);
    endtask

    task automatic wait_gap(input int i);
        do @(posedge ref_clk); while (ad[i] == 8'h00);
        do @(posedge ref_clk); while (ad[i] != 8'h00);
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        rstn        = 1'b0;
        tri_sel     = 2'h1;
        errors      = 0;
        checks_done = 0;
        cyc         = 0;
        lf          = 16'h3ec8;
        ebank       = 1'b0;
        en1         = 1'b1;
        efmt        = '{FMT_CODEB, FMT_CODEB};
        chk_en      = '{1'b0, 1'b0};
        tim_en      = '{1'b1, 1'b1};
        sd_e        = '{1'b0, 1'b0};
        for (int n = 0; n < 8; n++) begin
            wa[n] = 8'hff;
            nb[n] = 4'hf;
        end
        repeat (16) @(posedge ref_clk);
        chk({dg0, sg0, dg1, sg1}, 32'h00ff_ff00);
        rstn <= 1'b1;
        @(posedge ref_clk);
        bus.xfer(1'b1, REG_CTRL, 32'h0, 4'hf, q);
        chk(q, 32'h30);
        bus.xfer(1'b1, 6'h10, 32'h0, 4'hf, q);
        chk(q, 32'h0);
        bus.xfer(1'b0, REG_DIGIT0, 32'h12, 4'he, q);
        bus.xfer(1'b1, REG_DIGIT0, 32'h0, 4'hf, q);
        chk(q, 32'h8f);
        $display("test bus done");
        ctl(8'h70);
        tri_sel <= 2'h3;
        efmt[1] = FMT_HEX;
        pass(0, 0, "hex low");
        pass(8, 0, "hex high");
        bus.xfer(1'b1, REG_DIGIT0 + 6'hc, 32'h0, 4'hf, q);
        chk(q, {24'h0, wa[3][7], 3'h0, wa[3][3:0]});
        ctl(8'h30);
        tri_sel <= 2'h2;
        efmt[1] = FMT_CODEB;
        pass(0, 0, "codeb low");
        pass(8, 0, "codeb high");
        pass(0, 1, "codeb random");
        pass(255, 2, "codeb blank");
        ctl(8'h10);
        pass(0, 1, "raw random");
        pass(128, 2, "raw blank");
        en1 = 1'b0;
        ctl(8'h38);
        pass(0, 1, "bank b");
        ctl(8'h30);
        look("bank a");
        ctl(8'h18);
        look("raw ignores bank");
        wait_gap(0);
        tim_en[0] <= 1'b0;
        ctl(8'h60);
        repeat (2) @(posedge ref_clk);
        sd_e[0] <= 1'b1;
        pass(0, 1, "shutdown writes");
        // status in shutdown: not scanning, hex, slot position held
        bus.xfer(1'b1, REG_STATUS, 32'h0, 4'hf, q);
        chk(q, {22'h0, 2'h0, 1'b0, 3'(ORD[pos[0]]), 4'h0});
        sd_e[0] <= 1'b0;
        ctl(8'h70);
        tim_en[0] <= 1'b1;
        look("shutdown restart");
        wait_gap(1);
        tim_en[1] <= 1'b0;
        tri_sel   <= 2'h0;
        repeat (6) @(posedge ref_clk);
        sd_e[1] <= 1'b1;
        repeat (200) @(posedge ref_clk);
        sd_e[1]   <= 1'b0;
        tri_sel   <= 2'h3;
        tim_en[1] <= 1'b1;
        // both memories hold the shutdown writes, so check hex on the pin part
        efmt[1] = FMT_HEX;
        en1     = 1'b1;
        look("pin shutdown");
        give_verdict();
    end
endmodule // led_decode_scan_driver_tb
